// ### verilog/roi_start_address_loader.sv
// Readout-window start address loader with row and column scan registers.
//
// Notes on behaviour
// - Sixteen shift cells share clock and load.
// - Rising load edge updates outputs; else hold.
// - Data captured on rising shift clock, 20 MHz.
// - First bit is row LSB; last column MSB.
// - Row field ten bits, column field six.
// - Column steps of 32; only 40 codes accepted.
// - Row start selects any of 1024 lines.
// - Sync pulse copies start into scan register.
// - Column end-of-scan pulses at last position.
`timescale 1ns/1ps
module roi_start_address_loader (
  // Core clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serial upload link
  input wire logic spi_clk,
  input wire logic spi_data,
  input wire logic load_addr,
  // Readout timing pins from the controller
  input wire logic row_clk,
  input wire logic row_sync,
  input wire logic col_clk,
  input wire logic col_sync,
  // Loaded start addresses
  output logic [9:0] row_window_start,
  output logic [5:0] column_window_start,
  // Row scan state
  output logic [9:0] row_sel,
  output logic row_eos,
  // Column scan state
  output logic [5:0] col_block,
  output logic col_valid,
  output logic col_eos
);

  // ****************************************************************
  // Serial chain on the link clock
  // ****************************************************************
  // Parallel view of the chain; quasi-static whenever load is high,
  // because the controller stops the link clock before raising it.
  logic [15:0] chain_word;

  roi_shift_chain u_chain (
    .spi_clk(spi_clk),
    .rst(rst),
    .spi_data(spi_data),
    .word(chain_word)
  );

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Stage one of each chain is read only by stage two.
  logic load_s1_q, load_s2_q, load_s3_q;
  logic load_s1_d, load_s2_d, load_s3_d;
  logic rclk_s1_q, rclk_s2_q, rclk_s3_q;
  logic rclk_s1_d, rclk_s2_d, rclk_s3_d;
  logic rsync_s1_q, rsync_s2_q;
  logic rsync_s1_d, rsync_s2_d;
  logic cclk_s1_q, cclk_s2_q, cclk_s3_q;
  logic cclk_s1_d, cclk_s2_d, cclk_s3_d;
  logic csync_s1_q, csync_s2_q;
  logic csync_s1_d, csync_s2_d;

  // Next values of the synchroniser stages; the third stage of each
  // clock-like pin is kept only for edge detection.
  always_comb begin
    load_s1_d = load_addr;
    load_s2_d = load_s1_q;
    load_s3_d = load_s2_q;
    rclk_s1_d = row_clk;
    rclk_s2_d = rclk_s1_q;
    rclk_s3_d = rclk_s2_q;
    rsync_s1_d = row_sync;
    rsync_s2_d = rsync_s1_q;
    cclk_s1_d = col_clk;
    cclk_s2_d = cclk_s1_q;
    cclk_s3_d = cclk_s2_q;
    csync_s1_d = col_sync;
    csync_s2_d = csync_s1_q;
  end

  // Synchroniser registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {load_s1_q, load_s2_q, load_s3_q} <= 3'h0;
      {rclk_s1_q, rclk_s2_q, rclk_s3_q} <= 3'h0;
      {rsync_s1_q, rsync_s2_q} <= 2'h0;
      {cclk_s1_q, cclk_s2_q, cclk_s3_q} <= 3'h0;
      {csync_s1_q, csync_s2_q} <= 2'h0;
    end else begin
      {load_s1_q, load_s2_q, load_s3_q} <= {load_s1_d, load_s2_d, load_s3_d};
      {rclk_s1_q, rclk_s2_q, rclk_s3_q} <= {rclk_s1_d, rclk_s2_d, rclk_s3_d};
      {rsync_s1_q, rsync_s2_q} <= {rsync_s1_d, rsync_s2_d};
      {cclk_s1_q, cclk_s2_q, cclk_s3_q} <= {cclk_s1_d, cclk_s2_d, cclk_s3_d};
      {csync_s1_q, csync_s2_q} <= {csync_s1_d, csync_s2_d};
    end
  end

  // Edge events in the core domain.
  logic load_rise;
  logic row_rise;
  logic col_rise;
  assign load_rise = roi_pkg::roi_rise(load_s2_q, load_s3_q);
  assign row_rise = roi_pkg::roi_rise(rclk_s2_q, rclk_s3_q);
  assign col_rise = roi_pkg::roi_rise(cclk_s2_q, cclk_s3_q);

  // ****************************************************************
  // Start address registers
  // ****************************************************************
  logic [9:0] row_start_q, row_start_d;
  logic [5:0] col_start_q, col_start_d;

  // The word is taken only on the load rising edge; the chain is read
  // here only then, when the link clock is known to be still.
  always_comb begin
    row_start_d = row_start_q;
    col_start_d = col_start_q;
    if (load_rise) begin
      row_start_d = chain_word[roi_pkg::ROW_LSB +: roi_pkg::ROW_W];
      col_start_d = chain_word[roi_pkg::COL_LSB +: roi_pkg::COL_W];
    end
  end

  // Address registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_start_q <= roi_pkg::ROW_START_RST;
      col_start_q <= roi_pkg::COL_START_RST;
    end else begin
      row_start_q <= row_start_d;
      col_start_q <= col_start_d;
    end
  end

  // ****************************************************************
  // Row scan register
  // ****************************************************************
  logic [9:0] row_pos_q, row_pos_d;
  logic row_run_q, row_run_d;
  logic row_eos_q, row_eos_d;

  // A sync seen at a row clock edge selects the start line and keeps it
  // while sync stays high; otherwise each edge of a running scan steps one line, and the edge at the last line stops the scan.
  always_comb begin
    row_pos_d = row_pos_q;
    row_run_d = row_run_q;
    row_eos_d = 1'b0;
    if (row_rise) begin
      if (rsync_s2_q) begin
        row_pos_d = row_start_q;
        row_run_d = 1'b1;
      end else if (row_run_q && (row_pos_q != roi_pkg::ROW_LAST)) begin
        row_pos_d = row_pos_q + 10'h001;
        row_eos_d = (row_pos_d == roi_pkg::ROW_LAST);
      end else begin
        row_run_d = 1'b0;
      end
    end
  end

  // Row scan registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_pos_q <= roi_pkg::ROW_START_RST;
      row_run_q <= 1'b0;
      row_eos_q <= 1'b0;
    end else begin
      row_pos_q <= row_pos_d;
      row_run_q <= row_run_d;
      row_eos_q <= row_eos_d;
    end
  end

  // ****************************************************************
  // Column scan register
  // ****************************************************************
  roi_pkg::roi_scan_type col_state_q, col_state_d;
  logic [5:0] col_pos_q, col_pos_d;
  logic col_eos_q, col_eos_d, col_valid_q, col_valid_d;

  // A start code of 40 or above selects no block at all, which is how
  // the decoder ignores the upper codes of the six-bit field.
  always_comb begin
    col_state_d = col_state_q;
    col_pos_d = col_pos_q;
    col_eos_d = 1'b0;
    if (col_rise) begin
      if (csync_s2_q) begin
        if (roi_pkg::roi_col_ok(col_start_q)) begin
          col_pos_d = col_start_q;
          col_state_d = (col_start_q == roi_pkg::COL_LAST) ? roi_pkg::SCAN_LAST : roi_pkg::SCAN_RUN;
        end else begin
          col_state_d = roi_pkg::SCAN_IDLE;
        end
      end else begin
        unique case (col_state_q)
          roi_pkg::SCAN_IDLE: begin
            col_state_d = roi_pkg::SCAN_IDLE;
          end
          roi_pkg::SCAN_RUN: begin
            col_pos_d = col_pos_q + 6'h01;
            col_state_d = (col_pos_d == roi_pkg::COL_LAST) ? roi_pkg::SCAN_LAST : roi_pkg::SCAN_RUN;
          end
          roi_pkg::SCAN_LAST: begin
            col_state_d = roi_pkg::SCAN_IDLE;
          end
          default: begin
            col_state_d = roi_pkg::SCAN_IDLE;
          end
        endcase
      end
      col_eos_d = (col_state_d == roi_pkg::SCAN_LAST);
    end
    col_valid_d = (col_state_d != roi_pkg::SCAN_IDLE);
  end

  // Column scan registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_state_q <= roi_pkg::SCAN_IDLE;
      col_pos_q <= roi_pkg::COL_START_RST;
      col_eos_q <= 1'b0;
      col_valid_q <= 1'b0;
    end else begin
      col_state_q <= col_state_d;
      col_pos_q <= col_pos_d;
      col_eos_q <= col_eos_d;
      col_valid_q <= col_valid_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign row_window_start = row_start_q;
  assign column_window_start = col_start_q;
  assign row_sel = row_pos_q;
  assign row_eos = row_eos_q;
  assign col_block = col_pos_q;
  assign col_valid = col_valid_q;
  assign col_eos = col_eos_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // A load edge followed by the updated row field in the next cycle.
  sequence load_then_row_s;
    load_rise ##1 (row_start_q == $past(chain_word[9:0]));
  endsequence
  load_row_xfer_a: assert property (
    @(posedge clk) disable iff (rst)
    load_rise |-> load_then_row_s)
    else $error("Row start not taken from chain on load.");
  load_col_xfer_a: assert property (
    @(posedge clk) disable iff (rst)
    load_rise |=> (col_start_q == $past(chain_word[15:10])))
    else $error("Column start not taken from chain on load.");
  addr_hold_a: assert property (
    @(posedge clk) disable iff (rst)
    !load_rise |=> $stable(row_start_q) && $stable(col_start_q))
    else $error("Start address changed without a load edge.");
  row_sync_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (row_rise && rsync_s2_q) |=> (row_pos_q == $past(row_start_q)) && row_run_q)
    else $error("Row sync did not load the row start.");
  row_step_a: assert property (
    @(posedge clk) disable iff (rst)
    (row_rise && !rsync_s2_q && row_run_q && (row_pos_q != roi_pkg::ROW_LAST))
      |=> (row_pos_q == $past(row_pos_q) + 10'h001))
    else $error("Row scan did not step by one line.");
  col_sync_load_a: assert property (
    @(posedge clk) disable iff (rst)
    (col_rise && csync_s2_q && (col_start_q <= roi_pkg::COL_LAST))
      |=> (col_pos_q == $past(col_start_q)) && col_valid)
    else $error("Column sync did not load the column start.");
  col_reject_a: assert property (
    @(posedge clk) disable iff (rst)
    (col_rise && csync_s2_q && (col_start_q > roi_pkg::COL_LAST)) |=> !col_valid)
    else $error("Column code above 39 was accepted.");
  // End of scan appears at the last block and lasts one cycle.
  sequence eos_pulse_s;
    (col_eos_q && (col_pos_q == roi_pkg::COL_LAST)) ##1 !col_eos_q;
  endsequence
  col_eos_pulse_a: assert property (
    @(posedge clk) disable iff (rst)
    col_eos_q |-> eos_pulse_s)
    else $error("Column end of scan wrong position or width.");
endmodule // roi_start_address_loader

// ### verilog/roi_pkg.sv
// Shared constants and types for the readout-window start address loader.
package roi_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  // Width of the serial upload word.
  localparam int ADDR_W = 16;
  // Width and position of the row start field (first shifted bits).
  localparam int ROW_W = 10;
  localparam int ROW_LSB = 0;
  // Width and position of the column block start field (last shifted bits).
  localparam int COL_W = 6;
  localparam int COL_LSB = 10;

  // ****************************************************************
  // Scan ranges
  // ****************************************************************
  // Last row position; the row field covers 1024 lines.
  localparam logic [9:0] ROW_LAST = 10'h3ff;
  // Last column block; only 40 blocks of 32 columns exist.
  localparam logic [5:0] COL_LAST = 6'h27;
  // Columns per column block, for reference by users of col_block.
  localparam int COL_BLOCK_COLS = 32;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [9:0] ROW_START_RST = 10'h000;
  localparam logic [5:0] COL_START_RST = 6'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  // Highest serial shift clock rate the chain must accept, in MHz.
  localparam int SPI_FMAX_MHZ = 20;
  // Core clock rate in MHz.
  localparam int CLK_MHZ = 25;

  // Column scan state, Gray coded along idle, run, last.
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b00,
    SCAN_RUN = 2'b01,
    SCAN_LAST = 2'b11
  } roi_scan_type;

  // Rising edge of a synchronised level, from its last two samples.
  function automatic logic roi_rise(input logic now, input logic was);
    return now & ~was;
  endfunction

  // The column decoder accepts only the lowest 40 block codes.
  function automatic logic roi_col_ok(input logic [5:0] blk);
    return blk <= COL_LAST;
  endfunction

endpackage

// ### verilog/roi_shift_chain.sv
// Sixteen-cell serial shift chain clocked by the upload link clock.
`timescale 1ns/1ps
module roi_shift_chain (
  // Link clock and reset
  input wire logic spi_clk,
  input wire logic rst,
  // Serial data from the controller
  input wire logic spi_data,
  // Parallel view of the chain
  output logic [15:0] word
);

  // ****************************************************************
  // Shift cells
  // ****************************************************************
  // Chain contents; bit 0 ends up holding the first shifted bit.
  logic [15:0] word_q;
  logic [15:0] word_d;

  // New bits enter at the top so that, after sixteen clocks, the first
  // bit sits at bit 0 and the last at bit 15; extra clocks simply push
  // the oldest bits out of the bottom.
  always_comb begin
    word_d = {spi_data, word_q[15:1]};
  end

  // The cells carry no documented reset; a reset to zero is kept only so
  // that simulation starts from a defined chain.
  always_ff @(posedge spi_clk or posedge rst) begin
    if (rst) begin
      word_q <= roi_pkg::WORD_RST;
    end else begin
      word_q <= word_d;
    end
  end

  assign word = word_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Each link clock edge shifts the chain by one and takes in the data bit.
  shift_step_a: assert property (
    @(posedge spi_clk) disable iff (rst)
    1'b1 |=> (word_q[15] == $past(spi_data)) && (word_q[14:0] == $past(word_q[15:1])))
    else $error("Shift chain did not advance by one bit.");

endmodule // roi_shift_chain

// ### sim/roi_ctrl_model.sv
// Camera controller model that shifts and loads a start address word.
`timescale 1ns/1ps
module roi_ctrl_model (
  // Serial upload link
  output logic spi_clk,
  output logic spi_data,
  output logic load_addr
);
  // ****************************************************************
  // Idle levels
  // ****************************************************************
  // The link clock stands low between frames and the strobe is low.
  initial begin
    spi_clk = 1'b0;
    spi_data = 1'b0;
    load_addr = 1'b0;
  end

  // Shifts n bits, lowest first, on an 80 ns link clock.
  // Data changes only while the clock is low, so each rising edge sees a settled bit.
  task automatic shift(input logic [31:0] bits, input int n);
    // A small offset keeps the link clock out of phase with the core clock.
    #7;
    for (int i = 0; i < n; i++) begin
      spi_data = bits[i];
      #40 spi_clk = 1'b1;
      #40 spi_clk = 1'b0;
    end
    // A released data line must not keep showing the last bit.
    spi_data = ~spi_data;
  endtask

  // Raises the strobe well after the last falling clock edge, then drops it.
  task automatic load();
    #17 load_addr = 1'b1;
    #200 load_addr = 1'b0;
    #200;
  endtask
endmodule // roi_ctrl_model

// ### sim/testbench.sv
// Self-checking testbench for the start address loader.
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Clock, reset and pins
  // ****************************************************************
  logic clk;
  logic rst;
  logic spi_clk;
  logic spi_data;
  logic load_addr;
  logic row_clk;
  logic row_sync;
  logic col_clk;
  logic col_sync;
  logic [9:0] row_window_start;
  logic [5:0] column_window_start;
  logic [9:0] row_sel;
  logic row_eos;
  logic [5:0] col_block;
  logic col_valid;
  logic col_eos;
  // Tallies of mismatches, comparisons and end-of-scan pulses.
  int bad_count = 0;
  int num_checks = 0;
  int row_eos_n = 0;
  int col_eos_n = 0;
  // Reference state of the scan model.
  int exp_row;
  int exp_col;
  int exp_cv;
  int exp_re;
  int exp_ce;

  roi_start_address_loader dut (.clk(clk), .rst(rst), .spi_clk(spi_clk), .spi_data(spi_data),
    .load_addr(load_addr), .row_clk(row_clk), .row_sync(row_sync), .col_clk(col_clk),
    .col_sync(col_sync), .row_window_start(row_window_start),
    .column_window_start(column_window_start), .row_sel(row_sel), .row_eos(row_eos),
    .col_block(col_block), .col_valid(col_valid), .col_eos(col_eos));
  roi_ctrl_model ctrl (.spi_clk(spi_clk), .spi_data(spi_data), .load_addr(load_addr));

  // The core clock runs at 25 MHz.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // One-cycle pulses are counted here so that none slips between checks.
  always @(posedge clk) begin
    if (row_eos === 1'b1) row_eos_n++;
    if (col_eos === 1'b1) col_eos_n++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Uploads a word with extra leading bits and checks the loaded fields.
  task automatic upload(input logic [15:0] w);
    logic [15:0] old;
    old = {column_window_start, row_window_start};
    ctrl.shift({12'h000, w, 4'ha}, 20);
    check({column_window_start, row_window_start}, old);
    ctrl.load();
    check({6'h00, row_window_start}, {6'h00, w[9:0]});
    check({10'h000, column_window_start}, {10'h000, w[15:10]});
  endtask

  // One rising edge on both readout clocks, with or without sync, then the model step.
  // Sync is held over the whole clock high phase so it spans exactly one rising edge.
  task automatic pulse(input bit sync, input int rs, input int cs);
    @(posedge clk);
    row_sync <= sync;
    col_sync <= sync;
    wait_clk(3);
    row_clk <= 1'b1;
    col_clk <= 1'b1;
    wait_clk(4);
    row_clk <= 1'b0;
    col_clk <= 1'b0;
    wait_clk(2);
    row_sync <= 1'b0;
    col_sync <= 1'b0;
    wait_clk(3);
    if (sync) begin
      exp_row = rs;
      exp_col = cs;
      exp_cv = (cs <= 39);
      exp_ce += (cs == 39);
    end else begin
      if (exp_row < 1023) begin
        exp_row++;
        exp_re += (exp_row == 1023);
      end
      if (exp_cv == 1 && exp_col == 39) exp_cv = 0;
      else if (exp_cv == 1) begin
        exp_col++;
        exp_ce += (exp_col == 39);
      end
    end
    check({6'h00, row_sel}, exp_row[15:0]);
    check({15'h0000, col_valid}, exp_cv[15:0]);
    if (exp_cv == 1) check({10'h000, col_block}, exp_col[15:0]);
    check(row_eos_n[15:0], exp_re[15:0]);
    check(col_eos_n[15:0], exp_ce[15:0]);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [9:0] rs;
    logic [5:0] cs;
    rst = 1'b1;
    row_clk = 1'b0;
    row_sync = 1'b0;
    col_clk = 1'b0;
    col_sync = 1'b0;
    exp_re = 0;
    exp_ce = 0;
    void'($urandom(85));
    wait_clk(4);
    check({column_window_start, row_window_start}, 16'h0000);
    rst <= 1'b0;
    wait_clk(4);
    // The address goes up before any readout clock moves.
    upload(16'h5a5a);
    upload(16'ha5a5);
    $display("upload test done");
    // Three windows: two near the scan ends, one random row with a rejected column.
    for (int k = 0; k < 3; k++) begin
      rs = (k == 2) ? 10'($urandom % 1024) : 10'h3fd;
      cs = (k == 0) ? 6'h25 : (k == 1) ? 6'h27 : 6'(40 + $urandom % 24);
      upload({cs, rs});
      pulse(1'b1, rs, cs);
      for (int j = 0; j < 3; j++) pulse(1'b0, 0, 0);
      $display("scan test %0d done", k);
    end
    complete_run();
  end

  // Cuts a hung run short and counts it as a mismatch.
  initial begin
    #3000000;
    bad_count++;
    complete_run();
  end
endmodule // testbench
